// ==== hdl/gp_ports.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "gp_defs.svh"


module gp_ports (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // host register bus
   input wire logic bus_sel,
   input wire logic [7:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire gp_pkg::gp_byte_t bus_wdata,
   output gp_pkg::gp_byte_t bus_rdata,
   output logic bus_rvalid,
   // bus modes
   input wire logic data_port_mode,
   input wire logic jtag_en,
   input wire gp_pkg::gp_byte_t addr_lat_a,
   input wire gp_pkg::gp_byte_t addr_lat_b,
   input wire logic supply_below_batt,
   // logic array
   input wire gp_pkg::gp_byte_t oe_pt_a,
   input wire gp_pkg::gp_byte_t oe_pt_b,
   input wire gp_pkg::gp_byte_t oe_pt_c,
   input wire logic [2:0] oe_pt_d,
   input wire logic [2:0] ecs_pt,
   input wire logic [15:0] cell_next,
   input wire logic [15:0] cell_ld,
   input wire logic [2:0] in_cell_capture,
   output logic [15:0] cell_out,
   output logic [23:0] in_cell_bus,
   // pins
   input wire gp_pkg::gp_byte_t pa_in,
   output gp_pkg::gp_byte_t pa_out,
   output gp_pkg::gp_byte_t pa_oe,
   input wire gp_pkg::gp_byte_t pb_in,
   output gp_pkg::gp_byte_t pb_out,
   output gp_pkg::gp_byte_t pb_oe,
   input wire gp_pkg::gp_byte_t pc_in,
   output gp_pkg::gp_byte_t pc_out,
   output gp_pkg::gp_byte_t pc_oe,
   input wire logic [2:0] pd_in,
   output logic [2:0] pd_out,
   output logic [2:0] pd_oe,
   output logic [3:0] slew_fast_a,
   output logic [3:0] slew_fast_b,
   output logic [2:0] slew_fast_d,
   // dedicated pin functions
   output logic addr_strobe,
   output logic common_logic_clock,
   output logic io_space_disable,
   output logic data_byte_enable
);
   import gp_pkg::*;

   // ****************************************
   // reset release
   // ****************************************
   logic [1:0] rs_q;
   logic rst_n;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rs_q <= 2'b00;
      end else begin
         rs_q <= {rs_q[0], 1'b1};
      end
   end
   assign rst_n = rs_q[1];

   // ****************************************
   // decode
   // ****************************************
   gp_byte_t out_q [4];
   gp_byte_t dir_q [4];
   gp_byte_t drv_q [4];
   gp_byte_t ctrl_q [2];
   gp_byte_t spec_q;
   gp_byte_t ecs_q;
   gp_byte_t rd_val;
   gp_byte_t rdata_q;
   logic rvalid_q;
   logic [5:0] code;
   logic [1:0] port;
   logic blocked;
   logic wr_ok;
   logic rd_ok;
   logic rf;
   logic rs;
   logic [1:0] grp;
   gp_byte_t pmask;
   gp_cell_if cif ();

   assign code = bus_addr[7:2];
   assign port = bus_addr[1:0];
   assign rf = spec_q[`GP_SP_ROUTE_FIRST_B];
   assign rs = spec_q[`GP_SP_ROUTE_SECOND_C];
   assign blocked = spec_q[`GP_SP_CSI_EN] & pd_in[2];
   assign wr_ok = bus_sel & bus_wr & ~blocked;
   assign rd_ok = bus_sel & bus_rd & ~blocked;
   assign grp = gp_cell_grp(port, rf, rs);
   assign pmask = gp_port_mask(port);

   // ****************************************
   // configuration and data registers
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int p = 0; p < 4; p++) begin
            out_q[p] <= `GP_CFG_RST;
            dir_q[p] <= `GP_CFG_RST;
            drv_q[p] <= `GP_CFG_RST;
         end
      end else if (wr_ok) begin
         if (code == `GP_REG_OUT_DATA) begin
            out_q[port] <= bus_wdata & pmask;
         end else if (code == `GP_REG_DIR) begin
            dir_q[port] <= bus_wdata & pmask;
         end else if (code == `GP_REG_DRIVE) begin
            drv_q[port] <= bus_wdata & pmask;
         end
      end
   end

   // address-out control exists on A and B only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q[0] <= `GP_CFG_RST;
         ctrl_q[1] <= `GP_CFG_RST;
      end else if (wr_ok && code == `GP_REG_CTRL && !port[1]) begin
         ctrl_q[port[0]] <= bus_wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         spec_q <= `GP_CFG_RST;
         ecs_q <= `GP_CFG_RST;
      end else if (wr_ok && port == GP_PORT_A) begin
         if (code == `GP_REG_SPECIAL) begin
            spec_q <= bus_wdata;
         end else if (code == `GP_REG_ECS) begin
            ecs_q <= bus_wdata & 8'h77;
         end
      end
   end

   // ****************************************
   // cells
   // ****************************************
   assign cif.wdata = bus_wdata;
   assign cif.wr_cell = {3{wr_ok && code == `GP_REG_OCELL}} & (3'b001 << port);
   assign cif.wr_mask = {3{wr_ok && code == `GP_REG_OMASK}} & (3'b001 << port);
   assign cif.rf = rf;
   assign cif.rs = rs;
   assign cif.cell_next = cell_next;
   assign cif.cell_ld = cell_ld;
   assign cif.pad_in = {pc_in, pb_in, pa_in};
   // address inputs are held transparent while the strobe is high
   assign cif.icap = in_cell_capture | {3{spec_q[`GP_SP_ALE_EN] & pd_in[0]}};
   assign cell_out = cif.cell_q;
   assign in_cell_bus = cif.icell_q;

   gp_cell_bank u_bank (
      .clk(clk),
      .rst_n(rst_n),
      .cif(cif)
   );

   // ****************************************
   // pin composition
   // ****************************************
   gp_byte_t val_a, val_b, val_c, oe_a, oe_b, oe_c, od_a, od_b;
   logic [2:0] val_d, oe_d, ded_d;

   always_comb begin
      val_a = rf ? out_q[0] : cif.cell_q[7:0];
      val_a = (ctrl_q[0] & addr_lat_a) | (~ctrl_q[0] & val_a);
      oe_a = dir_q[0] | oe_pt_a;
      od_a = {drv_q[0][7:4], 4'h0};
      if (data_port_mode) begin
         val_a = rdata_q;
         oe_a = {8{rvalid_q}};
         od_a = 8'h00;
      end
   end

   always_comb begin
      val_b = rf ? cif.cell_q[7:0] : (rs ? out_q[1] : cif.cell_q[15:8]);
      val_b = (ctrl_q[1] & addr_lat_b) | (~ctrl_q[1] & val_b);
      oe_b = dir_q[1] | oe_pt_b;
      od_b = {drv_q[1][7:4], 4'h0};
   end

   always_comb begin
      val_c = rs ? cif.cell_q[15:8] : out_q[2];
      oe_c = dir_q[2] | oe_pt_c;
      if (spec_q[`GP_SP_BATT_IND_EN]) begin
         val_c[4] = supply_below_batt;
         oe_c[4] = 1'b1;
      end
      if (spec_q[`GP_SP_BATT_IN_EN]) begin
         oe_c[2] = 1'b0;
      end
      if (spec_q[`GP_SP_DBE_EN]) begin
         oe_c[7] = 1'b0;
      end
      if (jtag_en) begin
         oe_c = 8'h00;
      end
   end

   always_comb begin
      ded_d = {spec_q[`GP_SP_CSI_EN], spec_q[`GP_SP_CLK_EN], spec_q[`GP_SP_ALE_EN]};
      for (int i = 0; i < 3; i++) begin
         val_d[i] = ecs_q[i] ? ~(ecs_pt[i] ^ ecs_q[`GP_ECS_POL_LSB + i]) : out_q[3][i];
      end
      oe_d = (dir_q[3][2:0] | oe_pt_d) & ~ded_d;
   end

   gp_pin_drv #(.W(8)) u_pa (.val(val_a), .oe_req(oe_a), .od(od_a), .pad_out(pa_out), .pad_oe(pa_oe));
   gp_pin_drv #(.W(8)) u_pb (.val(val_b), .oe_req(oe_b), .od(od_b), .pad_out(pb_out), .pad_oe(pb_oe));
   gp_pin_drv #(.W(8)) u_pc (.val(val_c), .oe_req(oe_c), .od(drv_q[2]), .pad_out(pc_out), .pad_oe(pc_oe));
   gp_pin_drv #(.W(3)) u_pd (.val(val_d), .oe_req(oe_d), .od(3'b000), .pad_out(pd_out), .pad_oe(pd_oe));

   assign slew_fast_a = drv_q[0][3:0];
   assign slew_fast_b = drv_q[1][3:0];
   assign slew_fast_d = drv_q[3][2:0];
   assign addr_strobe = spec_q[`GP_SP_ALE_EN] & pd_in[0];
   assign common_logic_clock = spec_q[`GP_SP_CLK_EN] & pd_in[1];
   assign io_space_disable = blocked;
   assign data_byte_enable = spec_q[`GP_SP_DBE_EN] & pc_in[7];

   // ****************************************
   // read path
   // ****************************************
   // reads are pure muxes, nothing is popped or cleared
   always_comb begin
      rd_val = 8'h00;
      if (code == `GP_REG_PIN_IN) begin
         rd_val = (port == GP_PORT_A) ? pa_in : (port == GP_PORT_B) ? pb_in :
                  (port == GP_PORT_C) ? pc_in : {5'h00, pd_in};
      end else if (code == `GP_REG_OUT_DATA) begin
         rd_val = out_q[port];
      end else if (code == `GP_REG_OCELL && grp[1]) begin
         rd_val = grp[0] ? cif.cell_q[15:8] : cif.cell_q[7:0];
      end else if (code == `GP_REG_OMASK && grp[1]) begin
         rd_val = grp[0] ? cif.mask_q[15:8] : cif.mask_q[7:0];
      end else if (code == `GP_REG_ICELL && !(&port)) begin
         rd_val = cif.icell_q[port*8 +: 8];
      end else if (code == `GP_REG_ENOUT) begin
         rd_val = (port == GP_PORT_A) ? pa_oe : (port == GP_PORT_B) ? pb_oe :
                  (port == GP_PORT_C) ? pc_oe : 8'h00;
      end else if (code == `GP_REG_CTRL && !port[1]) begin
         rd_val = ctrl_q[port[0]];
      end else if (code == `GP_REG_DIR) begin
         rd_val = dir_q[port];
      end else if (code == `GP_REG_DRIVE) begin
         rd_val = drv_q[port];
      end else if (code == `GP_REG_SPECIAL && port == GP_PORT_A) begin
         rd_val = spec_q;
      end else if (code == `GP_REG_ECS && port == GP_PORT_A) begin
         rd_val = ecs_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= rd_ok;
         if (rd_ok) begin
            rdata_q <= rd_val;
         end
      end
   end
   assign bus_rdata = rdata_q;
   assign bus_rvalid = rvalid_q;

   // ****************************************
   // checks
   // ****************************************
   property p_pin_read;
      @(posedge clk) disable iff (!rst_n)
      (rd_ok && code == `GP_REG_PIN_IN && port == GP_PORT_B) |=> (bus_rvalid && bus_rdata == $past(pb_in));
   endproperty
   a_pin_read: assert property (p_pin_read) else $error("pin input read wrong");

   property p_out_readback;
      @(posedge clk) disable iff (!rst_n)
      (wr_ok && code == `GP_REG_OUT_DATA && port == GP_PORT_B) ##1
      (rd_ok && code == `GP_REG_OUT_DATA && port == GP_PORT_B)
      |=> (bus_rdata == $past(bus_wdata, 2));
   endproperty
   a_out_readback: assert property (p_out_readback) else $error("output data readback wrong");

   property p_drive_b;
      @(posedge clk) disable iff (!rst_n)
      (!rf && rs && ctrl_q[1] == 8'h00 && drv_q[1][7:4] == 4'h0)
      |-> (pb_out == out_q[1] && pb_oe == (dir_q[1] | oe_pt_b));
   endproperty
   a_drive_b: assert property (p_drive_b) else $error("port b drive wrong");

   property p_enout;
      @(posedge clk) disable iff (!rst_n)
      (rd_ok && code == `GP_REG_ENOUT && port == GP_PORT_C) |=> (bus_rdata == $past(pc_oe));
   endproperty
   a_enout: assert property (p_enout) else $error("enable out read wrong");

   property p_ro_write;
      @(posedge clk) disable iff (!rst_n)
      (bus_sel && bus_wr && code == `GP_REG_PIN_IN) |=> (out_q[port] == $past(out_q[port]) && $stable(spec_q));
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("read-only write changed state");

   property p_csi_block;
      @(posedge clk) disable iff (!rst_n)
      (bus_sel && bus_wr && blocked && code == `GP_REG_DIR) |=> (dir_q[$past(port)] == $past(dir_q[port]));
   endproperty
   a_csi_block: assert property (p_csi_block) else $error("write taken while deselected");

   property p_ecs_pol;
      @(posedge clk) disable iff (!rst_n)
      (ecs_q[0] && !ded_d[0]) |-> (pd_out[0] == (ecs_q[`GP_ECS_POL_LSB] ? ecs_pt[0] : ~ecs_pt[0]));
   endproperty
   a_ecs_pol: assert property (p_ecs_pol) else $error("external select polarity wrong");

   property p_d_no_cells;
      @(posedge clk) disable iff (!rst_n)
      (rd_ok && port == GP_PORT_D && (code == `GP_REG_OCELL || code == `GP_REG_ICELL)) |=> (bus_rdata == 8'h00);
   endproperty
   a_d_no_cells: assert property (p_d_no_cells) else $error("cell register seen on port d");
endmodule

`default_nettype wire

// ==== hdl/gp_defs.svh ====
`ifndef GP_DEFS_SVH
`define GP_DEFS_SVH

// ****************************************
// register codes, address = {code, port}
// ****************************************
`define GP_REG_PIN_IN 6'h00
`define GP_REG_OUT_DATA 6'h01
`define GP_REG_OCELL 6'h02
`define GP_REG_OMASK 6'h03
`define GP_REG_ICELL 6'h04
`define GP_REG_ENOUT 6'h05
`define GP_REG_CTRL 6'h06
`define GP_REG_DIR 6'h07
`define GP_REG_DRIVE 6'h08
`define GP_REG_SPECIAL 6'h09
`define GP_REG_ECS 6'h0A

// ****************************************
// field positions and reset values
// ****************************************
`define GP_SP_ROUTE_FIRST_B 0
`define GP_SP_ROUTE_SECOND_C 1
`define GP_SP_ALE_EN 2
`define GP_SP_CLK_EN 3
`define GP_SP_CSI_EN 4
`define GP_SP_DBE_EN 5
`define GP_SP_BATT_IN_EN 6
`define GP_SP_BATT_IND_EN 7
`define GP_ECS_POL_LSB 4
`define GP_CFG_RST 8'h00
`define GP_CELL_RST 16'h0000
`define GP_ICELL_RST 24'h00_0000
`define GP_PORT_D_MASK 8'h07
`define GP_PORT_FULL_MASK 8'hFF

`endif

// ==== hdl/gp_pkg.sv ====
`default_nettype none
`include "gp_defs.svh"

package gp_pkg;

   typedef logic [7:0] gp_byte_t;

   typedef enum logic [1:0] {
      GP_PORT_A = 2'b00,
      GP_PORT_B = 2'b01,
      GP_PORT_C = 2'b10,
      GP_PORT_D = 2'b11
   } gp_port_e;

   // which cell group a port's cell registers reach: {valid, group}
   function automatic logic [1:0] gp_cell_grp(input logic [1:0] port, input logic rf, input logic rs);
      logic [1:0] g;
      g = 2'b00;
      if (port == GP_PORT_A) begin
         g = {~rf, 1'b0};
      end else if (port == GP_PORT_B) begin
         if (rf) begin
            g = 2'b10;
         end else if (!rs) begin
            g = 2'b11;
         end
      end else if (port == GP_PORT_C) begin
         g = {rs, 1'b1};
      end
      return g;
   endfunction

   // only three pins exist on the last port
   function automatic gp_byte_t gp_port_mask(input logic [1:0] port);
      return (port == GP_PORT_D) ? gp_byte_t'(`GP_PORT_D_MASK) : gp_byte_t'(`GP_PORT_FULL_MASK);
   endfunction

endpackage

`default_nettype wire

// ==== hdl/gp_cell_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface gp_cell_if;
   logic [7:0] wdata;
   logic [2:0] wr_cell;
   logic [2:0] wr_mask;
   logic rf;
   logic rs;
   logic [15:0] cell_next;
   logic [15:0] cell_ld;
   logic [2:0] icap;
   logic [23:0] pad_in;
   logic [15:0] cell_q;
   logic [15:0] mask_q;
   logic [23:0] icell_q;

   modport bank (
      input wdata, wr_cell, wr_mask, rf, rs, cell_next, cell_ld, icap, pad_in,
      output cell_q, mask_q, icell_q
   );
   modport ctl (
      output wdata, wr_cell, wr_mask, rf, rs, cell_next, cell_ld, icap, pad_in,
      input cell_q, mask_q, icell_q
   );
endinterface

`default_nettype wire

// ==== hdl/gp_pin_drv.sv ====
`timescale 1ns/1ps
`default_nettype none

module gp_pin_drv #(
   parameter int W = 8
) (
   // pin request
   input wire logic [W-1:0] val,
   input wire logic [W-1:0] oe_req,
   input wire logic [W-1:0] od,
   // pad
   output logic [W-1:0] pad_out,
   output logic [W-1:0] pad_oe
);
   // open drain only pulls low; a high releases the pin to the pull-up
   assign pad_out = val & ~od;
   assign pad_oe = oe_req & ~(od & val);
endmodule

`default_nettype wire

// ==== hdl/gp_cell_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "gp_defs.svh"

module gp_cell_bank (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // cell access
   gp_cell_if.bank cif
);
   import gp_pkg::*;

   logic [1:0] wr_grp;
   logic [1:0] msk_grp;

   always_comb begin
      logic [1:0] g;
      g = 2'b00;
      wr_grp = 2'b00;
      msk_grp = 2'b00;
      for (int p = 0; p < 3; p++) begin
         g = gp_cell_grp(2'(p), cif.rf, cif.rs);
         if (g[1] && cif.wr_cell[p]) begin
            wr_grp[g[0]] = 1'b1;
         end
         if (g[1] && cif.wr_mask[p]) begin
            msk_grp[g[0]] = 1'b1;
         end
      end
   end

   // ****************************************
   // output cells
   // ****************************************
   // host load beats the array's own load in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cif.cell_q <= `GP_CELL_RST;
      end else begin
         for (int i = 0; i < 16; i++) begin
            if (wr_grp[i/8] && !cif.mask_q[i]) begin
               cif.cell_q[i] <= cif.wdata[i%8];
            end else if (cif.cell_ld[i]) begin
               cif.cell_q[i] <= cif.cell_next[i];
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cif.mask_q <= `GP_CELL_RST;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (msk_grp[i]) begin
               cif.mask_q[i*8 +: 8] <= cif.wdata;
            end
         end
      end
   end

   // ****************************************
   // input cells
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cif.icell_q <= `GP_ICELL_RST;
      end else begin
         for (int p = 0; p < 3; p++) begin
            if (cif.icap[p]) begin
               cif.icell_q[p*8 +: 8] <= cif.pad_in[p*8 +: 8];
            end
         end
      end
   end

   property p_masked_hold;
      @(posedge clk) disable iff (!rst_n)
      (wr_grp[0] && cif.mask_q[0] && !cif.cell_ld[0]) |=> (cif.cell_q[0] == $past(cif.cell_q[0]));
   endproperty
   a_masked_hold: assert property (p_masked_hold) else $error("masked cell was loaded");

   property p_unmasked_load;
      @(posedge clk) disable iff (!rst_n)
      (wr_grp[1] && cif.mask_q[15:8] == 8'h00) |=> (cif.cell_q[15:8] == $past(cif.wdata));
   endproperty
   a_unmasked_load: assert property (p_unmasked_load) else $error("unmasked cell not loaded");
endmodule

`default_nettype wire

// ==== bench/gp_pin_env.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// pin side: driven bits show the pad, released bits the outside level
// ****************************************
module gp_pin_env #(
   parameter int W = 8
) (
   // pad side
   input wire logic [W-1:0] pad_out,
   input wire logic [W-1:0] pad_oe,
   // outside world
   input wire logic [W-1:0] ext,
   output logic [W-1:0] pin
);
   assign pin = (pad_oe & pad_out) | (~pad_oe & ext);
endmodule

`default_nettype wire

// ==== bench/gp_ports_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "gp_defs.svh"

module gp_ports_bench;
   import gp_pkg::*;
   // ****************************************
   // stimulus and pins
   // ****************************************
   logic clk = 0, arst_n = 0, sel = 0, wr = 0, rd = 0, rv, iod;
   logic [7:0] addr = 0;
   gp_byte_t wd = 0, rdat, ea = 0, eb = 0, ec = 0, oea = 0, oec = 0, z8 = 0;
   gp_byte_t pa_i, pa_o, pa_e, pb_i, pb_o, pb_e, pc_i, pc_o, pc_e;
   logic [2:0] ed = 0, pd_i, pd_o, pd_e, icap = 0, z3 = 0, ept = 0, sfd;
   logic [15:0] co, cnx = 0, cld = 0;
   logic jt = 0, sbb = 0, ast, clkq, dbe;
   logic [3:0] sfa, sfb;
   logic [23:0] icb;
   int miscompares = 0, check_count = 0;

   gp_ports dut (.clk(clk), .arst_n(arst_n), .bus_sel(sel), .bus_addr(addr), .bus_wr(wr),
      .bus_rd(rd), .bus_wdata(wd), .bus_rdata(rdat), .bus_rvalid(rv), .data_port_mode(1'b0),
      .jtag_en(jt), .addr_lat_a(z8), .addr_lat_b(z8), .supply_below_batt(sbb),
      .oe_pt_a(oea), .oe_pt_b(z8), .oe_pt_c(oec), .oe_pt_d(z3), .ecs_pt(ept),
      .cell_next(cnx), .cell_ld(cld), .in_cell_capture(icap), .cell_out(co), .in_cell_bus(icb),
      .pa_in(pa_i), .pa_out(pa_o), .pa_oe(pa_e), .pb_in(pb_i), .pb_out(pb_o), .pb_oe(pb_e),
      .pc_in(pc_i), .pc_out(pc_o), .pc_oe(pc_e), .pd_in(pd_i), .pd_out(pd_o), .pd_oe(pd_e),
      .slew_fast_a(sfa), .slew_fast_b(sfb), .slew_fast_d(sfd), .addr_strobe(ast), .common_logic_clock(clkq),
      .io_space_disable(iod), .data_byte_enable(dbe));
   gp_pin_env #(.W(8)) env_a (.pad_out(pa_o), .pad_oe(pa_e), .ext(ea), .pin(pa_i));
   gp_pin_env #(.W(8)) env_b (.pad_out(pb_o), .pad_oe(pb_e), .ext(eb), .pin(pb_i));
   gp_pin_env #(.W(8)) env_c (.pad_out(pc_o), .pad_oe(pc_e), .ext(ec), .pin(pc_i));
   gp_pin_env #(.W(3)) env_d (.pad_out(pd_o), .pad_oe(pd_e), .ext(ed), .pin(pd_i));

   initial begin
      forever #50 clk = ~clk;
   end

   // ****************************************
   // bus tasks
   // ****************************************
   task automatic print_verdict;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic wr_reg(input logic [5:0] c, input logic [1:0] p, input gp_byte_t d);
      @(posedge clk);
      sel <= 1'b1;
      wr <= 1'b1;
      addr <= {c, p};
      wd <= d;
      @(posedge clk);
      sel <= 1'b0;
      wr <= 1'b0;
   endtask

   // answer is registered on the taking edge and checked 1 ns after it
   task automatic rd_chk(input string n, input logic [5:0] c, input logic [1:0] p, input gp_byte_t e);
      @(posedge clk);
      sel <= 1'b1;
      rd <= 1'b1;
      addr <= {c, p};
      @(posedge clk);
      sel <= 1'b0;
      rd <= 1'b0;
      #1;
      chk("rvalid", 8'h01, {7'h00, rv});
      chk(n, e, rdat);
   endtask

   // ****************************************
   // tests
   // ****************************************
   initial begin
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd_chk("dir_c", `GP_REG_DIR, 2, 8'h00);
      rd_chk("mask_a", `GP_REG_OMASK, 0, 8'h00);
      rd_chk("enout_c", `GP_REG_ENOUT, 2, 8'h00);
      $display("test reset done");
      wr_reg(`GP_REG_OUT_DATA, 2, 8'h5A);
      rd_chk("out_c", `GP_REG_OUT_DATA, 2, 8'h5A);
      @(posedge clk);
      oec <= 8'h0F;
      #1;
      chk("pin_c", 8'h0A, pc_i);
      rd_chk("enout_c", `GP_REG_ENOUT, 2, 8'h0F);
      wr_reg(`GP_REG_DIR, 2, 8'hF0);
      rd_chk("enout_c", `GP_REG_ENOUT, 2, 8'hFF);
      rd_chk("in_c", `GP_REG_PIN_IN, 2, 8'h5A);
      $display("test output data done");
      @(posedge clk);
      eb <= 8'hC3;
      icap <= 3'b010;
      rd_chk("in_b", `GP_REG_PIN_IN, 1, 8'hC3);
      wr_reg(`GP_REG_PIN_IN, 1, 8'h00);
      wr_reg(`GP_REG_ENOUT, 1, 8'hFF);
      rd_chk("enout_b", `GP_REG_ENOUT, 1, 8'h00);
      @(posedge clk);
      icap <= 3'b000;
      eb <= 8'h3C;
      rd_chk("icell_b", `GP_REG_ICELL, 1, 8'hC3);
      chk("icell_bus", 8'hC3, icb[15:8]);
      rd_chk("in_b", `GP_REG_PIN_IN, 1, 8'h3C);
      $display("test input done");
      wr_reg(`GP_REG_OMASK, 0, 8'h0F);
      rd_chk("mask_a", `GP_REG_OMASK, 0, 8'h0F);
      wr_reg(`GP_REG_OCELL, 0, 8'hFF);
      rd_chk("ocell_a", `GP_REG_OCELL, 0, 8'hF0);
      chk("cell_out", 8'hF0, co[7:0]);
      wr_reg(`GP_REG_OUT_DATA, 3, 8'hFF);
      rd_chk("out_d", `GP_REG_OUT_DATA, 3, 8'h07);
      wr_reg(`GP_REG_OCELL, 3, 8'hFF);
      rd_chk("ocell_d", `GP_REG_OCELL, 3, 8'h00);
      wr_reg(`GP_REG_OCELL, 1, 8'hA5);
      rd_chk("ocell_b", `GP_REG_OCELL, 1, 8'hA5);
      chk("cell_out_hi", 8'hA5, co[15:8]);
      // the array's own load still reaches masked cells
      @(posedge clk);
      cld <= 16'h000F;
      cnx <= 16'h0005;
      @(posedge clk);
      cld <= 16'h0000;
      rd_chk("ocell_a", `GP_REG_OCELL, 0, 8'hF5);
      $display("test cells done");
      @(posedge clk);
      oea <= 8'h01;
      rd_chk("enout_a", `GP_REG_ENOUT, 0, 8'h01);
      rd_chk("in_a", `GP_REG_PIN_IN, 0, 8'h01);
      wr_reg(`GP_REG_DRIVE, 0, 8'h15);
      wr_reg(`GP_REG_DIR, 0, 8'hFF);
      // open-drain pin 4 is released while high, so the outside low shows
      rd_chk("in_a_od", `GP_REG_PIN_IN, 0, 8'hE5);
      rd_chk("enout_a", `GP_REG_ENOUT, 0, 8'hEF);
      chk("slew_a", 8'h05, {4'h0, sfa});
      wr_reg(`GP_REG_SPECIAL, 0, 8'h02);
      wr_reg(`GP_REG_DIR, 1, 8'hFF);
      // write then read back in the very next cycle
      @(posedge clk);
      sel <= 1'b1;
      wr <= 1'b1;
      addr <= {`GP_REG_OUT_DATA, 2'd1};
      wd <= 8'h69;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      sel <= 1'b0;
      rd <= 1'b0;
      #1;
      chk("rvalid", 8'h01, {7'h00, rv});
      chk("out_b", 8'h69, rdat);
      rd_chk("in_b", `GP_REG_PIN_IN, 1, 8'h69);
      rd_chk("ocell_c", `GP_REG_OCELL, 2, 8'hA5);
      rd_chk("in_c", `GP_REG_PIN_IN, 2, 8'hA5);
      $display("test routing done");
      wr_reg(`GP_REG_SPECIAL, 0, 8'h10);
      ed <= 3'b100;
      @(posedge clk);
      #1;
      chk("io_off", 8'h01, {7'h00, iod});
      wr_reg(`GP_REG_OUT_DATA, 2, 8'h00);
      wr_reg(`GP_REG_DIR, 2, 8'h00);
      ed <= 3'b000;
      rd_chk("out_c", `GP_REG_OUT_DATA, 2, 8'h5A);
      rd_chk("dir_c", `GP_REG_DIR, 2, 8'hF0);
      $display("test select done");
      wr_reg(`GP_REG_SPECIAL, 0, 8'h80);
      rd_chk("in_c_batt", `GP_REG_PIN_IN, 2, 8'h4A);
      @(posedge clk);
      sbb <= 1'b1;
      jt <= 1'b1;
      rd_chk("enout_c", `GP_REG_ENOUT, 2, 8'h00);
      @(posedge clk);
      jt <= 1'b0;
      rd_chk("in_c_batt", `GP_REG_PIN_IN, 2, 8'h5A);
      wr_reg(`GP_REG_ECS, 0, 8'h11);
      wr_reg(`GP_REG_DIR, 3, 8'h01);
      ept <= 3'b001;
      rd_chk("in_d", `GP_REG_PIN_IN, 3, 8'h01);
      rd_chk("enout_d", `GP_REG_ENOUT, 3, 8'h00);
      wr_reg(`GP_REG_ECS, 0, 8'h01);
      rd_chk("in_d", `GP_REG_PIN_IN, 3, 8'h00);
      wr_reg(`GP_REG_SPECIAL, 0, 8'h2C);
      ed <= 3'b011;
      ec <= 8'h80;
      @(posedge clk);
      #1;
      chk("addr_strobe", 8'h01, {7'h00, ast});
      chk("logic_clock", 8'h01, {7'h00, clkq});
      chk("pd_oe", 8'h00, {5'h00, pd_e});
      chk("byte_enable", 8'h01, {7'h00, dbe});
      wr_reg(`GP_REG_DRIVE, 1, 8'h0A);
      wr_reg(`GP_REG_DRIVE, 3, 8'hFF);
      #1;
      chk("slew_b", 8'h0A, {4'h0, sfb});
      chk("slew_d", 8'h07, {5'h00, sfd});
      $display("test pin functions done");
      print_verdict();
   end

   // tests need about 130 cycles; 3000 cycles, over twenty times that, is a hang
   initial begin
      #(3000 * 100);
      miscompares++;
      print_verdict();
   end
endmodule

`default_nettype wire
